//--- fcb_pkg.sv
// Package with constants and types for the floating-point compare and branch block.
package fcb_pkg;
    // Primary opcode and sub-op encodings.
    localparam logic [5:0]  OP_FP_COPROC    = 6'h11;
    localparam logic [4:0]  SUB_BRANCH      = 5'h08;
    localparam logic [4:0]  FMT_SINGLE      = 5'h10;
    localparam logic [4:0]  FMT_DOUBLE      = 5'h11;
    localparam logic [1:0]  CMP_FUNC_HI     = 2'h3;
    // Instruction field positions.
    localparam int          OP_LSB          = 26;
    localparam int          FMT_LSB         = 21;
    localparam int          FT_LSB          = 16;
    localparam int          FS_LSB          = 11;
    localparam int          CMP_CC_LSB      = 8;
    localparam int          BR_CC_LSB       = 18;
    localparam int          BR_ND_BIT       = 17;
    localparam int          BR_TF_BIT       = 16;
    localparam int          OFFSET_SHIFT    = 2;
    // Control and status bit positions and reset values.
    localparam int          CS_COND_BIT     = 23;
    localparam int          CS_FLAG_INV_BIT = 6;
    localparam int          CS_EN_INV_BIT   = 11;
    localparam int          CS_CAUSE_INV_BIT = 16;
    localparam logic [31:0] CS_RESET        = 32'h0000_0000;
    localparam logic [7:0]  CC_RESET        = 8'h00;
    // Register bus map.
    localparam logic [7:0]  ADDR_CS         = 8'h00;
    localparam logic [7:0]  ADDR_CC         = 8'h04;
    localparam logic [7:0]  ADDR_CTRL       = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_CLR    = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_EN     = 8'h14;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    // Interrupt event bits.
    localparam int          EV_INVALID      = 0;
    localparam int          EV_TAKEN        = 1;
    localparam int          EV_NULLIFY      = 2;
    localparam int          EV_FAULT        = 3;
    localparam int          EV_N            = 4;
    // Exception codes presented with the exception strobe.
    typedef enum logic [1:0]
    {
        FCB_EXC_NONE    = 2'b00,
        FCB_EXC_UNUSABLE = 2'b01,
        FCB_EXC_RESERVED = 2'b10,
        FCB_EXC_INVALID = 2'b11
    } fcb_exc_t;
endpackage

//--- fcb_core.sv
// Floating-point compare and condition-code branch unit with an AHB-Lite register port.
`timescale 1ns/100ps
// Functional notes
// - Target is offset shifted left two, sign extended, plus delay-slot address.
// - True branch redirects only on code bit one, after the delay slot.
// - Likely forms not taken suppress the delay-slot instruction.
// - Condition is code bit equals tf; else nullify when nd set.
// - Branch decode: coprocessor opcode, sub-op 01000, nd and tf fields.
// - Eight condition bits; code 0 also drives condition signal and status C.
// - Compare decode: format, two sources, 3-bit code select, 4-bit predicate.
// - Comparison is exact and never overflows or underflows.
// - Without exception the result writes the chosen code bit, true as one.
// - Predicate bit 3 with any NaN raises Invalid Operation.
// - Invalid sets the flag; if enabled, no write and immediate exception.
// - Exactly one of greater, less, equal, unordered; NaN is unordered.
// - Positive and negative zero compare equal.
// - True branch tests the predicate, false branch tests its complement.
// - Result ORs less, equal, unordered by predicate bits; code 0 updates legacy.
// - False forms use tf zero and branch when the code bit is zero.
module fcb_core
#(
    parameter int ADDR_W = 32
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              issue_valid,
    input  wire logic [31:0]       issue_instr,
    input  wire logic [ADDR_W-1:0] issue_pc,
    input  wire logic [63:0]       fs_value,
    input  wire logic [63:0]       ft_value,
    output logic                   redirect_valid,
    output logic [ADDR_W-1:0]      redirect_target,
    output logic                   nullify_delay_slot,
    output logic                   exc_valid,
    output logic [1:0]             exc_code,
    output logic                   fp_condition_signal,
    output logic [7:0]             fp_condition_codes,
    output logic                   legacy_condition_input,
    output logic                   irq,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata
);
    localparam int     EV_N_W = fcb_pkg::EV_N;
    logic [31:0]       fp_control_status;
    logic [31:0]       ctrl;
    logic [EV_N_W-1:0] irq_stat;
    logic [EV_N_W-1:0] irq_en;
    logic              ph_valid;
    logic              ph_write;
    logic [7:0]        ph_addr;
    logic              wr_cs;
    logic              wr_ctrl;
    logic              wr_clr;
    logic              wr_en;

    // Test for NaN: all-ones exponent with a non-zero fraction.
    function automatic logic is_nan(input logic [63:0] v, input logic dbl);
        if (dbl)
            is_nan = (v[62:52] == 11'h7FF) && (v[51:0] != 52'h0);
        else
            is_nan = (v[30:23] == 8'hFF) && (v[22:0] != 23'h0);
    endfunction

    // Signed-magnitude less-than; zeros of either sign are treated as equal.
    function automatic logic mag_less(input logic [63:0] a, input logic [63:0] b,
                                      input logic dbl);
        logic        sa;
        logic        sb;
        logic [62:0] ma;
        logic [62:0] mb;
        sa = dbl ? a[63] : a[31];
        sb = dbl ? b[63] : b[31];
        ma = dbl ? a[62:0] : {32'h0, a[30:0]};
        mb = dbl ? b[62:0] : {32'h0, b[30:0]};
        if (ma == 63'h0 && mb == 63'h0)
            mag_less = 1'b0;
        else if (sa != sb)
            mag_less = sa;
        else
            mag_less = sa ? (ma > mb) : (ma < mb);
    endfunction

    // Instruction decode.
    logic       is_cop;
    logic       is_branch;
    logic       is_cmp;
    logic       fmt_dbl;
    logic       fmt_ok;
    logic [2:0] cc_sel;
    logic       nd;
    logic       tf;
    logic [3:0] pred;
    logic       cop_enabled;
    logic       legacy_mode;
    assign is_cop      = issue_instr[31:fcb_pkg::OP_LSB] == fcb_pkg::OP_FP_COPROC;
    assign is_branch   = is_cop && issue_instr[25:21] == fcb_pkg::SUB_BRANCH;
    assign fmt_dbl     = issue_instr[25:21] == fcb_pkg::FMT_DOUBLE;
    assign fmt_ok      = fmt_dbl || issue_instr[25:21] == fcb_pkg::FMT_SINGLE;
    assign is_cmp      = is_cop && fmt_ok && issue_instr[5:4] == fcb_pkg::CMP_FUNC_HI;
    assign nd          = issue_instr[fcb_pkg::BR_ND_BIT];
    assign tf          = issue_instr[fcb_pkg::BR_TF_BIT];
    assign pred        = issue_instr[3:0];
    assign cop_enabled = ctrl[0];
    assign legacy_mode = ctrl[1];
    // Legacy levels only know code 0, so the field is forced there.
    assign cc_sel = legacy_mode ? 3'h0 : (is_branch ? issue_instr[20:18] : issue_instr[10:8]);

    // Reserved when the code field is non-zero in legacy mode or compare pad bits are set.
    logic bad_enc;
    assign bad_enc = is_branch ? (legacy_mode && issue_instr[20:18] != 3'h0)
                   : (issue_instr[7:6] != 2'h0 || (legacy_mode && issue_instr[10:8] != 3'h0));

    // Ordering relations; at most one holds for any pair, none when greater.
    logic unord;
    logic less;
    logic equal;
    assign unord = is_nan(fs_value, fmt_dbl) || is_nan(ft_value, fmt_dbl);
    assign less  = !unord && mag_less(fs_value, ft_value, fmt_dbl);
    assign equal = !unord && !less && !mag_less(ft_value, fs_value, fmt_dbl);

    logic cmp_result;
    logic invalid;
    logic inv_trap;
    assign cmp_result = (pred[2] & less) | (pred[1] & equal) | (pred[0] & unord);
    assign invalid    = pred[3] && unord;
    assign inv_trap   = invalid && fp_control_status[fcb_pkg::CS_EN_INV_BIT];

    // Classified strobes for this issue.
    logic fault;
    logic do_cmp;
    logic do_br;
    assign fault  = issue_valid && (is_branch || is_cmp) && (!cop_enabled || bad_enc);
    assign do_cmp = issue_valid && is_cmp && !fault;
    assign do_br  = issue_valid && is_branch && !fault;

    // Branch condition: the code bit compared with tf covers true and false forms.
    logic br_cond;
    logic [ADDR_W-1:0] br_offset;
    assign br_cond   = fp_condition_codes[cc_sel] == tf;
    assign br_offset = ADDR_W'({{(ADDR_W-18){issue_instr[15]}}, issue_instr[15:0], 2'b00});

    // Condition codes; a trapped invalid compare leaves them unchanged.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fp_condition_codes <= fcb_pkg::CC_RESET;
        else if (do_cmp && !inv_trap)
            fp_condition_codes[cc_sel] <= cmp_result;
    end

    // Code 0 mirrors into the legacy condition input and the status C bit.
    assign fp_condition_signal    = fp_condition_codes[0];
    assign legacy_condition_input = fp_condition_codes[0];

    // Control and status: C bit mirrors code 0, sticky invalid flag, writable enables.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fp_control_status <= fcb_pkg::CS_RESET;
        else
        begin
            if (wr_cs)
                fp_control_status <= hwdata;
            fp_control_status[fcb_pkg::CS_COND_BIT] <= (do_cmp && !inv_trap && cc_sel == 3'h0)
                ? cmp_result : fp_condition_codes[0];
            if (do_cmp)
                fp_control_status[fcb_pkg::CS_CAUSE_INV_BIT] <= invalid;
            if (do_cmp && invalid)
                fp_control_status[fcb_pkg::CS_FLAG_INV_BIT] <= 1'b1;
        end
    end

    // Branch resolution is registered, so redirect lands after the delay slot issues.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            redirect_valid     <= 1'b0;
            redirect_target    <= '0;
            nullify_delay_slot <= 1'b0;
        end
        else
        begin
            redirect_valid     <= do_br && br_cond;
            redirect_target    <= issue_pc + ADDR_W'(4) + br_offset;
            nullify_delay_slot <= do_br && !br_cond && nd;
        end
    end

    // Exceptions: unusable outranks reserved, and the invalid trap is taken at once.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            exc_valid <= 1'b0;
            exc_code  <= fcb_pkg::FCB_EXC_NONE;
        end
        else
        begin
            exc_valid <= fault || (do_cmp && inv_trap);
            if (fault && !cop_enabled)
                exc_code <= fcb_pkg::FCB_EXC_UNUSABLE;
            else if (fault)
                exc_code <= fcb_pkg::FCB_EXC_RESERVED;
            else if (do_cmp && inv_trap)
                exc_code <= fcb_pkg::FCB_EXC_INVALID;
            else
                exc_code <= fcb_pkg::FCB_EXC_NONE;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_cs     = ph_valid && ph_write && ph_addr == fcb_pkg::ADDR_CS;
    assign wr_ctrl   = ph_valid && ph_write && ph_addr == fcb_pkg::ADDR_CTRL;
    assign wr_clr    = ph_valid && ph_write && ph_addr == fcb_pkg::ADDR_IRQ_CLR;
    assign wr_en     = ph_valid && ph_write && ph_addr == fcb_pkg::ADDR_IRQ_EN;

    // Address phase capture.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
        end
        else if (hready)
        begin
            ph_valid <= hsel && htrans[1];
            ph_write <= hwrite;
            ph_addr  <= haddr[7:0];
        end
    end

    // Read data is registered from the address phase; unmapped addresses read zero.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            unique case (haddr[7:0])
                fcb_pkg::ADDR_CS:       hrdata <= fp_control_status;
                fcb_pkg::ADDR_CC:       hrdata <= {24'h0, fp_condition_codes};
                fcb_pkg::ADDR_CTRL:     hrdata <= ctrl;
                fcb_pkg::ADDR_IRQ_STAT: hrdata <= {28'h0, irq_stat};
                fcb_pkg::ADDR_IRQ_EN:   hrdata <= {28'h0, irq_en};
                default:                hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control register: bit 0 coprocessor enable, bit 1 legacy single-code mode.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl <= fcb_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= {30'h0, hwdata[1:0]};
    end

    // Interrupt events; a new event in the clear cycle wins over the clear.
    logic [EV_N_W-1:0] ev;
    assign ev = {fault, do_br && !br_cond && nd, do_br && br_cond, do_cmp && invalid};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat <= '0;
            irq_en   <= '0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~(wr_clr ? hwdata[EV_N_W-1:0] : '0)) | ev;
            if (wr_en)
                irq_en <= hwdata[EV_N_W-1:0];
        end
    end
    assign irq = |(irq_stat & irq_en);

    // A branch is redirected or nullified, never both.
    redirect_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(redirect_valid && nullify_delay_slot))
        else $error("Redirect and nullify asserted together.");
    // Target is delay-slot address plus the scaled offset.
    target_calc_a: assert property (@(posedge clk) disable iff (!rst_n)
        do_br |=> redirect_target == $past(issue_pc) + ADDR_W'(4) + $past(br_offset))
        else $error("Branch target mismatch.");
    // True branch redirects one cycle later exactly when its bit is one.
    true_branch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (do_br && tf) |=> redirect_valid == $past(fp_condition_codes[cc_sel]))
        else $error("True branch redirect wrong.");
    // False branch redirects when the bit is zero.
    false_branch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (do_br && !tf) |=> redirect_valid == !$past(fp_condition_codes[cc_sel]))
        else $error("False branch redirect wrong.");
    // Likely branch not taken nullifies the slot.
    likely_null_a: assert property (@(posedge clk) disable iff (!rst_n)
        (do_br && nd && !br_cond) |=> nullify_delay_slot)
        else $error("Likely branch did not nullify.");
    // Trapped invalid compare leaves condition codes untouched.
    trap_nowrite_a: assert property (@(posedge clk) disable iff (!rst_n)
        (do_cmp && inv_trap) |=> $stable(fp_condition_codes) && exc_valid)
        else $error("Trapped compare wrote a code.");
    // Untrapped compare writes the predicate result.
    cmp_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (do_cmp && !inv_trap) |=> fp_condition_codes[$past(cc_sel)] == $past(cmp_result))
        else $error("Compare result not written.");
    // Invalid sets the sticky flag.
    inv_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (do_cmp && invalid) |=> fp_control_status[fcb_pkg::CS_FLAG_INV_BIT])
        else $error("Invalid flag not set.");
    // Disabled coprocessor raises Unusable.
    unusable_exc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue_valid && (is_branch || is_cmp) && !cop_enabled)
        |=> exc_valid && exc_code == fcb_pkg::FCB_EXC_UNUSABLE)
        else $error("Unusable exception missing.");
    // Relations are mutually exclusive, and identical non-NaN words always compare equal.
    rel_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot0({less, equal, unord}))
        else $error("Ordering relations overlap.");
    rel_equal_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!unord && fs_value == ft_value) |-> equal)
        else $error("Equal operands not reported equal.");
endmodule

//--- fcb_core_bench.sv
// Self-checking bench for the compare and branch unit, driven through its issue and bus ports.
`timescale 1ns/100ps
module fcb_core_bench;
    logic        clk;
    logic        rst_n;
    logic        issue_valid;
    logic [31:0] issue_instr;
    logic [31:0] issue_pc;
    logic [63:0] fs_value;
    logic [63:0] ft_value;
    logic        redirect_valid;
    logic [31:0] redirect_target;
    logic        nullify_delay_slot;
    logic        exc_valid;
    logic [1:0]  exc_code;
    logic        fp_condition_signal;
    logic [7:0]  fp_condition_codes;
    logic        legacy_condition_input;
    logic        irq;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [63:0] va [7];
    logic [63:0] vb [7];
    logic [2:0]  rel [7];
    logic [7:0]  cc_img;
    int          miscompares;
    int          n_checks;

    // The single slave's ready is the bus ready, so hready follows hreadyout.
    fcb_core fcb_core_inst
    (
        .clk(clk), .rst_n(rst_n), .issue_valid(issue_valid), .issue_instr(issue_instr),
        .issue_pc(issue_pc), .fs_value(fs_value), .ft_value(ft_value),
        .redirect_valid(redirect_valid), .redirect_target(redirect_target),
        .nullify_delay_slot(nullify_delay_slot), .exc_valid(exc_valid), .exc_code(exc_code),
        .fp_condition_signal(fp_condition_signal), .fp_condition_codes(fp_condition_codes),
        .legacy_condition_input(legacy_condition_input), .irq(irq), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
    );

    // Free-running 10 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Waits for ready at a rising edge; bounded so a stuck slave cannot hang the run.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 50)
            miscompares++;
    endtask

    // One single-word transfer: address phase held to ready, then the data phase.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
        // A write lands at this edge, so let it settle before anything looks at its effect.
        @(negedge clk);
    endtask

    // Issues one instruction and returns in the cycle where its one-cycle answer stands.
    task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
        @(posedge clk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        fs_value    <= a;
        ft_value    <= b;
        @(posedge clk);
        issue_valid <= 1'b0;
        @(negedge clk);
    endtask

    function automatic logic [31:0] cmp_op(input logic [4:0] fmt, input logic [2:0] cc,
                                           input logic [3:0] cnd);
        return {fcb_pkg::OP_FP_COPROC, fmt, 5'h02, 5'h04, cc, 2'b00, fcb_pkg::CMP_FUNC_HI, cnd};
    endfunction

    function automatic logic [31:0] br_op(input logic [2:0] cc, input logic nd, input logic tf,
                                          input logic [15:0] off);
        return {fcb_pkg::OP_FP_COPROC, fcb_pkg::SUB_BRANCH, cc, nd, tf, off};
    endfunction

    // Compare with the expected code image kept alongside; relations are given per pair.
    task automatic compare(input int i, input logic [2:0] cc, input logic [3:0] cnd);
        logic [4:0] fmt;
        fmt = (i == 6) ? fcb_pkg::FMT_SINGLE : fcb_pkg::FMT_DOUBLE;
        cc_img[cc] = (cnd[2] & rel[i][2]) | (cnd[1] & rel[i][1]) | (cnd[0] & rel[i][0]);
        issue(cmp_op(fmt, cc, cnd), va[i], vb[i]);
        chk("codes", 32'(cc_img), 32'(fp_condition_codes));
        chk("cond0", 32'(cc_img[0]), 32'(fp_condition_signal));
        chk("legacy", 32'(cc_img[0]), 32'(legacy_condition_input));
        chk("no exc", 32'h0, 32'(exc_valid));
    endtask

    // Branch checked against the code image; target is relative to the delay slot.
    task automatic branch(input logic [2:0] cc, input logic nd, input logic tf,
                          input logic [15:0] off);
        logic tk;
        tk = (cc_img[cc] == tf);
        issue(br_op(cc, nd, tf, off), 64'h0, 64'h0);
        chk("redirect", 32'(tk), 32'(redirect_valid));
        chk("nullify", 32'(!tk && nd), 32'(nullify_delay_slot));
        if (tk)
            chk("target", issue_pc + 32'h4 + {{14{off[15]}}, off, 2'b00}, redirect_target);
    endtask

    // A refused instruction raises its code and leaves the condition codes alone.
    task automatic fault(input logic [31:0] ins, input logic [1:0] code);
        issue(ins, va[3], vb[3]);
        chk("exc code", 32'(code), 32'(exc_code));
        chk("exc strobe", 32'h1, 32'(exc_valid));
        chk("no redirect", 32'h0, 32'(redirect_valid));
        chk("codes kept", 32'(cc_img), 32'(fp_condition_codes));
    endtask

    // Main sequence.
    initial
    begin
        rst_n = 1'b0;
        issue_valid = 1'b0;
        issue_instr = 32'h0;
        issue_pc = 32'h0000_1000;
        fs_value = 64'h0;
        ft_value = 64'h0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        miscompares = 0;
        n_checks = 0;
        cc_img = fcb_pkg::CC_RESET;
        // Pairs: less, greater, signed zeros, quiet NaN, signalling NaN with itself, mixed signs, single.
        va = '{64'h3FF0_0000_0000_0000, 64'h4000_0000_0000_0000, 64'h0, 64'h7FF8_0000_0000_0000,
               64'h7FF0_0000_0000_0001, 64'hBFF0_0000_0000_0000, 64'h7FF8_0000_3F80_0000};
        vb = '{64'h4000_0000_0000_0000, 64'h3FF0_0000_0000_0000, 64'h8000_0000_0000_0000,
               64'h3FF0_0000_0000_0000, 64'h7FF0_0000_0000_0001, 64'h3FF0_0000_0000_0000,
               64'hFFFF_FFFF_4000_0000};
        rel = '{3'b100, 3'b000, 3'b010, 3'b001, 3'b001, 3'b100, 3'b100};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, fcb_pkg::ADDR_CS, 32'h0);
        chk("cs reset", fcb_pkg::CS_RESET, rd);
        bus(1'b0, fcb_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl reset", fcb_pkg::CTRL_RESET, rd);
        bus(1'b0, fcb_pkg::ADDR_IRQ_EN, 32'h0);
        chk("irq en reset", 32'h0, rd);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int i = 0; i < 7; i++)
            for (int c = 0; c < 16; c++)
                compare(i, 3'(c + i), 4'(c));
        bus(1'b0, fcb_pkg::ADDR_CS, 32'h0);
        chk("flag", 32'h1, 32'(rd[fcb_pkg::CS_FLAG_INV_BIT]));
        chk("c bit", 32'(cc_img[0]), 32'(rd[fcb_pkg::CS_COND_BIT]));
        bus(1'b1, fcb_pkg::ADDR_CC, 32'h0000_00A5);
        bus(1'b0, fcb_pkg::ADDR_CC, 32'h0);
        chk("cc read only", 32'(cc_img), rd);
        for (int f = 0; f < 4; f++)
            for (int c = 0; c < 8; c++)
                branch(3'(c), f[1], f[0], c[0] ? 16'h8000 : 16'h7FFF);
        // Trap enabled: signalling predicate on a NaN writes nothing.
        bus(1'b1, fcb_pkg::ADDR_CS, 32'h1 << fcb_pkg::CS_EN_INV_BIT);
        fault(cmp_op(fcb_pkg::FMT_DOUBLE, 3'h2, 4'hF), 2'(fcb_pkg::FCB_EXC_INVALID));
        compare(3, 3'h2, 4'h7);
        // Interrupt: raised by a taken branch, masked, then cleared.
        bus(1'b1, fcb_pkg::ADDR_IRQ_CLR, 32'hF);
        bus(1'b1, fcb_pkg::ADDR_IRQ_EN, 32'hF);
        chk("irq idle", 32'h0, 32'(irq));
        branch(3'h0, 1'b0, cc_img[0], 16'h0004);
        bus(1'b0, fcb_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("irq stat", 32'h1 << fcb_pkg::EV_TAKEN, rd);
        chk("irq up", 32'h1, 32'(irq));
        bus(1'b1, fcb_pkg::ADDR_IRQ_EN, 32'h0);
        chk("irq masked", 32'h0, 32'(irq));
        bus(1'b1, fcb_pkg::ADDR_IRQ_CLR, 32'hF);
        bus(1'b0, fcb_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("irq cleared", 32'h0, rd);
        bus(1'b1, fcb_pkg::ADDR_IRQ_EN, 32'hF);
        // Coprocessor disabled, then legacy single-code mode.
        bus(1'b1, fcb_pkg::ADDR_CTRL, 32'h0);
        fault(cmp_op(fcb_pkg::FMT_DOUBLE, 3'h1, 4'h4), 2'(fcb_pkg::FCB_EXC_UNUSABLE));
        fault(br_op(3'h0, 1'b0, 1'b1, 16'h0010), 2'(fcb_pkg::FCB_EXC_UNUSABLE));
        chk("irq fault", 32'h1, 32'(irq));
        bus(1'b1, fcb_pkg::ADDR_CTRL, 32'h3);
        fault(cmp_op(fcb_pkg::FMT_DOUBLE, 3'h3, 4'h4), 2'(fcb_pkg::FCB_EXC_RESERVED));
        fault(br_op(3'h5, 1'b0, 1'b1, 16'h0010), 2'(fcb_pkg::FCB_EXC_RESERVED));
        compare(0, 3'h0, 4'h4);
        // An unrelated word separates compare and branch in legacy mode.
        issue(32'h0, 64'h0, 64'h0);
        chk("ignored", 32'h0, 32'(exc_valid | redirect_valid));
        branch(3'h0, 1'b1, 1'b1, 16'hFFFF);
        branch(3'h0, 1'b1, 1'b0, 16'hFFFF);
        tally_and_finish();
    end

    // Watchdog: the tests need well under a thousand cycles.
    initial
    begin
        #1000000;
        miscompares++;
        tally_and_finish();
    end
endmodule
